// ==== pss_pkg.sv ====
// Purpose: constants for the pixel source switch
// Assumes: indirect 8-bit register map, 8-bit colour channels
// Notes:   What this block does is listed below
// What this block does
// RQ1 - Window shows palette graphics in direct colour
// RQ2 - Window uses crosshair start/stop registers
// RQ3 - Select pin picks source every pixel
// RQ4 - Switching only in direct colour modes
// RQ5 - VGA switching needs one-to-one multiplex
// RQ6 - VGA port disables overlay and zoom
// RQ7 - Window control register at index 29h
// RQ8 - Window hidden unless both corners on-screen
// RQ9 - Key compares four channels against ranges
// RQ10 - VGA enabled means key uses VGA data
// RQ11 - Either function selects palette, palette wins
// RQ12 - Software sets both functions for direct
// RQ13 - External timing latches on VGA clock
// RQ14 - Control bits: select, window, invert
// RQ15 - Palette means VGA, overlay or pseudo
// RQ16 - Reset selects palette graphics
// RQ17 - Software avoids overlay switch without overlay
// RQ18 - Select pin latched with pixel data
// RQ19 - VGA data latched on VGA clock rise
// RQ20 - Self-clocked timing at most 50 MHz
// RQ21 - Pipeline keeps VGA and pixel aligned
// RQ22 - Multiple windows: select enable, pin high
// RQ23 - Switch is enabled OR, xor invert
// RQ24 - Key is channel AND, xor polarity
// RQ25 - Reset clears key enables, sets polarity
package pss_pkg;
    // Register indices of the indirect map
    localparam logic [7:0] IDX_AUX  = 8'h29;
    localparam logic [7:0] IDX_WIN0 = 8'h40;
    localparam logic [7:0] IDX_MUX2 = 8'h50;
    localparam logic [7:0] IDX_MODE = 8'h51;
    localparam logic [7:0] IDX_KEYC = 8'h52;
    localparam logic [7:0] IDX_STAT = 8'h53;
    localparam logic [7:0] IDX_RNG0 = 8'h58;
    // Field positions
    localparam int ACR_INV   = 0;
    localparam int ACR_WIN   = 1;
    localparam int ACR_PSEL  = 2;
    localparam int MUX2_VGA  = 7;
    localparam int MODE_DC   = 0;
    localparam int MODE_OVL  = 1;
    localparam int MODE_ONE  = 2;
    localparam int KEY_POL   = 4;
    // Reset values
    localparam logic [7:0] AUX_RST  = 8'h01;
    localparam logic [7:0] MUX2_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] KEYC_RST = 8'h10;
    // Screen coordinate width
    localparam int COORD_W = 16;
endpackage : pss_pkg

// ==== pss_switch.sv ====
// Purpose: per-pixel choice of direct colour or palette graphics
// Assumes: pixel, VGA and select inputs all move on vga_latch_clock
// Notes:   config crosses from mclk by a toggle handshake
`timescale 1ns/1ps
module pss_switch (
    input  wire logic       mclk,            // Register clock
    input  wire logic       srst,            // Sync reset, high
    input  wire logic [7:0] mpu_index,       // Indirect index
    input  wire logic [7:0] mpu_wdata,       // Write data
    input  wire logic       mpu_wr,          // Write strobe
    input  wire logic       mpu_rd,          // Read strobe
    output logic      [7:0] mpu_rdata,       // Read data
    output logic            hzoom_block,     // Zoom forced off
    input  wire logic       vga_latch_clock, // Pixel/VGA clock
    input  wire logic [7:0] pix_red,         // Direct red
    input  wire logic [7:0] pix_green,       // Direct green
    input  wire logic [7:0] pix_blue,        // Direct blue
    input  wire logic [7:0] ovl_data,        // Overlay index
    input  wire logic [7:0] vga_data,        // VGA index
    input  wire logic       src_select,      // Per-pixel select
    input  wire logic       disp_active,     // Active pixel
    input  wire logic       frame_start,     // Frame start
    output logic            out_pal_sel,     // 1 = palette
    output logic      [7:0] out_pal_idx,     // Palette index
    output logic      [7:0] out_red,         // Direct red
    output logic      [7:0] out_green,       // Direct green
    output logic      [7:0] out_blue,        // Direct blue
    output logic            out_active       // Active, aligned
);
    localparam int CW = pss_pkg::COORD_W;

    typedef struct packed {
        logic [2:0]          aux_window_control;
        logic                vga;
        logic                dc;
        logic                ovl;
        logic                one;
        logic [4:0]          ckc;
        logic [7:0][7:0]     rng;
        logic [3:0][CW-1:0]  win;
    } pss_cfg_t;

    typedef struct packed {
        logic [7:0]      aux;
        logic [7:0]      mux2;
        logic [7:0]      mode;
        logic [7:0]      keyc;
        logic [7:0][7:0] rng;
        logic [7:0][7:0] win;
        logic [7:0]      rdata;
        logic            zoom;
        logic            req;
        logic            ack_s1;
        logic            ack_s2;
        logic            busy;
        pss_cfg_t        shd;
    } pss_mst_t;

    typedef struct packed {
        logic          rst_s1;
        logic          rst_s2;
        logic          req_s1;
        logic          req_s2;
        logic          ack;
        pss_cfg_t      cfg;
        logic [7:0]    red;
        logic [7:0]    grn;
        logic [7:0]    blu;
        logic [7:0]    ovl;
        logic [7:0]    vga;
        logic          sel;
        logic          act;
        logic          frm;
        logic [CW-1:0] x;
        logic [CW-1:0] y;
        logic [CW-1:0] xl;
        logic [CW-1:0] yl;
        logic          o_sel;
        logic [7:0]    o_idx;
        logic [7:0]    o_r;
        logic [7:0]    o_g;
        logic [7:0]    o_b;
        logic          o_act;
    } pss_lnk_t;

    pss_mst_t        m, m_nxt;
    pss_lnk_t        l, l_nxt;
    pss_cfg_t        cfg_now;
    pss_cfg_t        c;
    logic [3:0][7:0] kd;
    logic [7:0]      pal_w;
    logic            hit_all;
    logic            key_w;
    logic            inwin_w;
    logic            sw_w;
    logic            sup_w;

    // Register side: writes, reads, handshake source
    always_comb begin
        m_nxt = m;
        m_nxt.ack_s1 = l.ack;
        m_nxt.ack_s2 = m.ack_s1;
        m_nxt.zoom   = m.mux2[pss_pkg::MUX2_VGA];
        // RQ2 shared window registers
        for (int k = 0; k < 4; k++) begin
            cfg_now.win[k] = {m.win[2*k+1], m.win[2*k]};
        end
        // RQ14 window format bits
        cfg_now.aux_window_control = m.aux[2:0];
        cfg_now.vga = m.mux2[pss_pkg::MUX2_VGA];
        cfg_now.dc  = m.mode[pss_pkg::MODE_DC];
        cfg_now.ovl = m.mode[pss_pkg::MODE_OVL];
        cfg_now.one = m.mode[pss_pkg::MODE_ONE];
        cfg_now.ckc = m.keyc[4:0];
        cfg_now.rng = m.rng;
        // RQ7 indirect register decode
        if (mpu_wr) begin
            case (mpu_index)
                pss_pkg::IDX_AUX:  m_nxt.aux  = mpu_wdata;
                pss_pkg::IDX_MUX2: m_nxt.mux2 = mpu_wdata;
                pss_pkg::IDX_MODE: m_nxt.mode = mpu_wdata;
                pss_pkg::IDX_KEYC: m_nxt.keyc = mpu_wdata;
                default: begin
                    if (mpu_index[7:3] == pss_pkg::IDX_WIN0[7:3]) begin
                        m_nxt.win[mpu_index[2:0]] = mpu_wdata;
                    end
                    if (mpu_index[7:3] == pss_pkg::IDX_RNG0[7:3]) begin
                        m_nxt.rng[mpu_index[2:0]] = mpu_wdata;
                    end
                end
            endcase
        end
        // Reads answer one cycle later; unmapped reads 00
        if (mpu_rd) begin
            case (mpu_index)
                pss_pkg::IDX_AUX:  m_nxt.rdata = m.aux;
                pss_pkg::IDX_MUX2: m_nxt.rdata = m.mux2;
                pss_pkg::IDX_MODE: m_nxt.rdata = m.mode;
                pss_pkg::IDX_KEYC: m_nxt.rdata = m.keyc;
                pss_pkg::IDX_STAT: m_nxt.rdata = {7'h00, cfg_now != m.shd};
                default: begin
                    m_nxt.rdata = 8'h00;
                    if (mpu_index[7:3] == pss_pkg::IDX_WIN0[7:3]) begin
                        m_nxt.rdata = m.win[mpu_index[2:0]];
                    end
                    if (mpu_index[7:3] == pss_pkg::IDX_RNG0[7:3]) begin
                        m_nxt.rdata = m.rng[mpu_index[2:0]];
                    end
                end
            endcase
        end
        // Shadow only moves while idle, so the link copies a stable word
        if (!m.busy) begin
            m_nxt.shd  = cfg_now;
            m_nxt.req  = ~m.req;
            m_nxt.busy = 1'b1;
        end else if (m.ack_s2 == m.req) begin
            m_nxt.busy = 1'b0;
        end
        // RQ25 key defaults to palette
        if (srst) begin
            m_nxt          = '0;
            m_nxt.aux      = pss_pkg::AUX_RST;
            m_nxt.mux2     = pss_pkg::MUX2_RST;
            m_nxt.mode     = pss_pkg::MODE_RST;
            m_nxt.keyc     = pss_pkg::KEYC_RST;
            m_nxt.shd.aux_window_control  = pss_pkg::AUX_RST[2:0];
            m_nxt.shd.ckc  = pss_pkg::KEYC_RST[4:0];
        end
    end

    // Register side state
    always_ff @(posedge mclk) begin
        m <= m_nxt;
    end

    // Link side: latch, count, compare, choose
    always_comb begin
        l_nxt = l;
        c = l.cfg;
        l_nxt.rst_s1 = srst;
        l_nxt.rst_s2 = l.rst_s1;
        l_nxt.req_s1 = m.req;
        l_nxt.req_s2 = l.req_s1;
        if (l.req_s2 != l.ack) begin
            l_nxt.cfg = m.shd;
            l_nxt.ack = l.req_s2;
        end
        // RQ18 select latched with pixels
        l_nxt.red = pix_red;
        l_nxt.grn = pix_green;
        l_nxt.blu = pix_blue;
        l_nxt.ovl = ovl_data;
        l_nxt.sel = src_select;
        l_nxt.act = disp_active;
        l_nxt.frm = frame_start;
        // RQ19 VGA latched on rise
        l_nxt.vga = vga_data;
        // Position of the latched pixel; last line/row measured live
        if (disp_active) begin
            l_nxt.x = l.act ? l.x + 16'h0001 : 16'h0000;
        end
        if (l.act && !disp_active) begin
            l_nxt.xl = l.x;
            l_nxt.y  = l.y + 16'h0001;
        end
        if (frame_start) begin
            l_nxt.y = 16'h0000;
            if (l.y != 16'h0000) begin
                l_nxt.yl = l.y - 16'h0001;
            end
        end
        // RQ10 VGA replaces overlay
        pal_w = c.vga ? l.vga : l.ovl;
        kd[0] = pal_w;
        kd[1] = l.red;
        kd[2] = l.grn;
        kd[3] = l.blu;
        // RQ9 four range compares
        hit_all = 1'b1;
        for (int i = 0; i < 4; i++) begin
            hit_all = hit_all & (~c.ckc[i] |
                      ((c.rng[2*i] <= kd[i]) && (kd[i] <= c.rng[2*i+1])));
        end
        // RQ24 key polarity xor
        key_w = hit_all ^ ~c.ckc[pss_pkg::KEY_POL];
        // RQ8 both corners on-screen
        inwin_w = l.act && (l.x >= c.win[0]) && (l.x <= c.win[2]) &&
                  (l.y >= c.win[1]) && (l.y <= c.win[3]) &&
                  (c.win[2] <= l.xl) && (c.win[3] <= l.yl);
        // RQ1 RQ3 RQ23 window/pin switch
        sw_w = ((inwin_w & c.aux_window_control[pss_pkg::ACR_WIN]) |
                (l.sel & c.aux_window_control[pss_pkg::ACR_PSEL])) ^ c.aux_window_control[pss_pkg::ACR_INV];
        // RQ5 VGA needs one-to-one
        sup_w = c.vga ? c.one : c.ovl;
        l_nxt.o_r   = l.red;
        l_nxt.o_g   = l.grn;
        l_nxt.o_b   = l.blu;
        l_nxt.o_act = l.act;
        // RQ4 direct colour modes only
        if (!c.dc) begin
            // RQ15 pseudo colour index
            l_nxt.o_sel = 1'b1;
            l_nxt.o_idx = l.red;
        end else begin
            // RQ11 either selects palette
            l_nxt.o_sel = sup_w & (sw_w | key_w);
            // RQ6 VGA port hides overlay
            l_nxt.o_idx = pal_w;
        end
        // RQ16 reset shows palette
        if (l.rst_s2) begin
            l_nxt         = '0;
            l_nxt.rst_s1  = srst;       // Plain chain, so reset can end
            l_nxt.rst_s2  = l.rst_s1;
            l_nxt.cfg.aux_window_control = pss_pkg::AUX_RST[2:0];
            l_nxt.cfg.ckc = pss_pkg::KEYC_RST[4:0];
            l_nxt.o_sel   = 1'b1;
        end
    end

    // RQ13 link logic on VGA clock
    always_ff @(posedge vga_latch_clock) begin
        l <= l_nxt;
    end

    // RQ21 equal pipeline both ports
    assign out_pal_sel = l.o_sel;
    assign out_pal_idx = l.o_idx;
    assign out_red     = l.o_r;
    assign out_green   = l.o_g;
    assign out_blue    = l.o_b;
    assign out_active  = l.o_act;
    assign mpu_rdata   = m.rdata;
    assign hzoom_block = m.zoom;

    property p_reset_dflt;
        @(posedge mclk) disable iff (srst)
        $fell(srst) |-> (m.aux == pss_pkg::AUX_RST) && (m.keyc == pss_pkg::KEYC_RST);
    endproperty
    a_reset_dflt: assert property (p_reset_dflt) // RQ25
        else $error("reset defaults wrong");
    property p_aux_write;
        @(posedge mclk) disable iff (srst)
        (mpu_wr && mpu_index == pss_pkg::IDX_AUX)
            |=> (m.aux[2:0] == $past(mpu_wdata[2:0]));
    endproperty
    a_aux_write: assert property (p_aux_write) // RQ7
        else $error("control write lost");
    property p_zoom;
        @(posedge mclk) disable iff (srst)
        m.mux2[pss_pkg::MUX2_VGA] |=> hzoom_block;
    endproperty
    a_zoom: assert property (p_zoom) // RQ6
        else $error("zoom not blocked");
    property p_or_pal;
        @(posedge vga_latch_clock) disable iff (l.rst_s2)
        (c.dc && sup_w && (sw_w || key_w)) |=> out_pal_sel;
    endproperty
    a_or_pal: assert property (p_or_pal) // RQ11
        else $error("palette not chosen");
    property p_pure_dc;
        @(posedge vga_latch_clock) disable iff (l.rst_s2)
        (c.dc && !sw_w && !key_w) |=> !out_pal_sel;
    endproperty
    a_pure_dc: assert property (p_pure_dc) // RQ23
        else $error("direct colour not chosen");
    property p_pseudo;
        @(posedge vga_latch_clock) disable iff (l.rst_s2)
        !c.dc |=> out_pal_sel && (out_pal_idx == $past(l.red));
    endproperty
    a_pseudo: assert property (p_pseudo) // RQ15
        else $error("pseudo colour path wrong");
    property p_vga_idx;
        @(posedge vga_latch_clock) disable iff (l.rst_s2)
        (c.dc && c.vga) |=> (out_pal_idx == $past(l.vga));
    endproperty
    a_vga_idx: assert property (p_vga_idx) // RQ10
        else $error("VGA index not used");
    property p_sel_pin;
        @(posedge vga_latch_clock) disable iff (l.rst_s2)
        (c.dc && sup_w && c.aux_window_control == 3'h4 && l.sel) |=> out_pal_sel;
    endproperty
    a_sel_pin: assert property (p_sel_pin) // RQ3
        else $error("select pin ignored");
    property p_stop_off;
        @(posedge vga_latch_clock) disable iff (l.rst_s2)
        (c.win[2] > l.xl) |-> !inwin_w;
    endproperty
    a_stop_off: assert property (p_stop_off) // RQ8
        else $error("window shown off-screen");
    property p_align;
        @(posedge vga_latch_clock) disable iff (l.rst_s2)
        $past(l.rst_s2, 2) == 1'b0 |-> (out_red == $past(pix_red, 2)) &&
            (out_active == $past(disp_active, 2));
    endproperty
    a_align: assert property (p_align) // RQ21
        else $error("pixel pipeline misaligned");
endmodule : pss_switch

// ==== pss_gfx_model.sv ====
// Purpose: graphics controller model driving the pixel stream
// Assumes: one pixel per link clock, externally clocked timing
// Notes:   data follows screen position so neighbouring pixels differ
`timescale 1ns/1ps
module pss_gfx_model #(
    parameter int ACT_W = 8, // Active pixels per line
    parameter int LINES = 4  // Active lines per frame
) (
    input  wire logic        pixel_latch_clock,   // Link clock
    output logic      [7:0]  red,    // Direct red
    output logic      [7:0]  green,  // Direct green
    output logic      [7:0]  blue,   // Direct blue
    output logic      [7:0]  ovl,    // Overlay index
    output logic      [7:0]  vga,    // VGA index
    output logic             pin,    // Per-pixel select
    output logic             act,    // Active pixel
    output logic             fst,    // Frame start
    output logic      [15:0] px,     // Column of pixel
    output logic      [15:0] py      // Line of pixel
);
    int hc = ACT_W + 3;
    int vc = LINES;
    // Quiet bus until the first link edge
    initial {red, green, blue, ovl, vga, pin, act, fst, px, py} = '0;
    always @(posedge pixel_latch_clock) begin
        #1;
        hc = (hc == ACT_W + 3) ? 0 : hc + 1;
        if (hc == 0) vc = (vc == LINES) ? 0 : vc + 1;
        act = (hc < ACT_W) && (vc < LINES);
        fst = (vc == LINES);
        px = 16'(hc);
        py = 16'(vc);
        red = 8'(hc * 16 + vc);
        green = 8'(hc * 8);
        blue = 8'(255 - hc * 16);
        ovl = 8'(vc * 16 + hc);
        vga = 8'(hc * 32 + vc);
        pin = hc[0] ^ vc[0];
    end
endmodule : pss_gfx_model

// ==== testbench.sv ====
// Purpose: self-checking bench for the pixel source switch
// Assumes: register shadow mirrors every write made here
// Notes:   decisions are predicted per pixel, one link edge late
`timescale 1ns/1ps
module testbench;
    localparam int ACT_W = 8;
    localparam int LINES = 4;
    localparam int FRAME = (ACT_W + 4) * (LINES + 1);
    logic        mclk = 1'b0;
    logic        pixel_latch_clock = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  mpu_index = 8'h00;
    logic [7:0]  mpu_wdata = 8'h00;
    logic        mpu_wr = 1'b0;
    logic        mpu_rd = 1'b0;
    logic [7:0]  mpu_rdata, red, green, blue, ovl, vga, o_idx, o_r, o_g, o_b, e_idx, p_idx;
    logic        hzoom_block, pin, act, fst, o_sel, o_act, e_sel, p_sel, e_act, p_act;
    logic [15:0] px, py;
    logic [23:0] e_rgb, p_rgb;
    int          fail_count = 0;
    int          checked = 0;
    int          cycles = 0;
    logic        chk_en = 1'b0;
    // Shadow of the programmed config, starting at reset values
    logic [7:0]  mode = 8'h00, mux2 = 8'h00, aux = 8'h01, keyc = 8'h10;
    logic [15:0] wv [4] = '{default: 16'h0000};
    logic [7:0]  rg [8] = '{default: 8'h00};

    always #2.5 mclk = ~mclk;
    always #32 pixel_latch_clock = ~pixel_latch_clock;

    pss_switch dut_u (.mclk(mclk), .srst(srst), .mpu_index(mpu_index),
        .mpu_wdata(mpu_wdata), .mpu_wr(mpu_wr), .mpu_rd(mpu_rd), .mpu_rdata(mpu_rdata),
        .hzoom_block(hzoom_block), .vga_latch_clock(pixel_latch_clock), .pix_red(red),
        .pix_green(green), .pix_blue(blue), .ovl_data(ovl), .vga_data(vga),
        .src_select(pin), .disp_active(act), .frame_start(fst), .out_pal_sel(o_sel),
        .out_pal_idx(o_idx), .out_red(o_r), .out_green(o_g), .out_blue(o_b),
        .out_active(o_act));
    pss_gfx_model #(.ACT_W(ACT_W), .LINES(LINES)) gfx_u (.pixel_latch_clock(pixel_latch_clock), .red(red),
        .green(green), .blue(blue), .ovl(ovl), .vga(vga), .pin(pin), .act(act),
        .fst(fst), .px(px), .py(py));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("fail_count=%0d checked=%0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    function automatic logic inr(input logic [7:0] v, input int i);
        return rg[2*i] <= v && v <= rg[2*i+1];
    endfunction : inr

    // Expected decision for the pixel now on the pins
    function automatic logic exp_sel();
        logic inwin, sw, key;
        inwin = act && wv[0] <= px && px <= wv[2] && wv[1] <= py && py <= wv[3]
                && wv[2] <= 16'(ACT_W - 1) && wv[3] <= 16'(LINES - 1);
        sw = ((inwin & aux[1]) | (pin & aux[2])) ^ aux[0];
        key = ((inr(mux2[7] ? vga : ovl, 0) | ~keyc[0]) & (inr(red, 1) | ~keyc[1])
              & (inr(green, 2) | ~keyc[2]) & (inr(blue, 3) | ~keyc[3])) ^ ~keyc[4];
        if (!mode[0]) return 1'b1;
        return (mux2[7] ? mode[2] : mode[1]) & (sw | key);
    endfunction : exp_sel

    // Predict at each latch edge, compare one edge later
    always @(posedge pixel_latch_clock) begin
        {p_sel, p_idx, p_rgb, p_act} = {e_sel, e_idx, e_rgb, e_act};
        e_sel = exp_sel();
        e_idx = !mode[0] ? red : (mux2[7] ? vga : ovl);
        e_rgb = {red, green, blue};
        e_act = act;
        #2;
        if (chk_en) begin
            check(32'(o_act), 32'(p_act), "active delay"); // aligned
            check(32'({o_r, o_g, o_b}), 32'(p_rgb), "direct colour"); // aligned
            if (p_act) check(32'(o_sel), 32'(p_sel), "source select");
            if (p_act && p_sel) check(32'(o_idx), 32'(p_idx), "palette index");
        end
    end

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge mclk) #1;
        mpu_index = idx;
        mpu_wdata = d;
        mpu_wr = 1'b1;
        @(posedge mclk) #1;
        mpu_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        @(posedge mclk) #1;
        mpu_index = idx;
        mpu_rd = 1'b1;
        @(posedge mclk) #1;
        mpu_rd = 1'b0;
        @(posedge mclk) #1;
        d = mpu_rdata;
    endtask : rd

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        rd(idx, d);
        check(32'(d), 32'(exp), "register read"); // register readback
    endtask : rd_chk

    task automatic set_cfg(input logic [7:0] m, input logic [7:0] x2, input logic [7:0] a,
                           input logic [7:0] k);
        {mode, mux2, aux, keyc} = {m, x2, a, k};
        wr(pss_pkg::IDX_MODE, m);
        wr(pss_pkg::IDX_MUX2, x2);
        wr(pss_pkg::IDX_AUX, a);
        wr(pss_pkg::IDX_KEYC, k);
    endtask : set_cfg

    task automatic set_win(input logic [15:0] xs, ys, xe, ye);
        wv = '{xs, ys, xe, ye};
        for (int i = 0; i < 8; i++) wr(pss_pkg::IDX_WIN0 + 8'(i), wv[i/2][8*(i%2) +: 8]);
    endtask : set_win

    // Wait for the link copy, let two frames pass, then judge one frame
    task automatic settle_check();
        logic [7:0] s;
        int n;
        s = 8'h01;
        n = 0;
        while (s[0] !== 1'b0 && n < 100) begin
            rd(pss_pkg::IDX_STAT, s);
            n++;
        end
        check(32'(s[0]), 32'h0, "config crossing"); // config taken into shadow
        repeat (2 * FRAME) @(posedge pixel_latch_clock);
        chk_en = 1'b1;
        repeat (FRAME) @(posedge pixel_latch_clock);
        chk_en = 1'b0;
    endtask : settle_check

    task automatic t_reset();
        rd_chk(pss_pkg::IDX_AUX, pss_pkg::AUX_RST); // aux default
        rd_chk(pss_pkg::IDX_KEYC, pss_pkg::KEYC_RST); // key default
        rd_chk(pss_pkg::IDX_MUX2, pss_pkg::MUX2_RST); // VGA port off
        rd_chk(8'h30, 8'h00); // unmapped reads zero
        settle_check(); // palette after reset
    endtask : t_reset

    task automatic t_nondirect();
        set_cfg(8'h00, 8'h80, 8'h06, 8'h0F);
        rd_chk(pss_pkg::IDX_AUX, 8'h06); // control readback
        check(32'(hzoom_block), 32'h1, "zoom blocked"); // VGA port on
        settle_check(); // palette outside direct colour
    endtask : t_nondirect

    task automatic t_window();
        set_win(16'h2, 16'h1, 16'h5, 16'h2);
        set_cfg(8'h07, 8'h80, 8'h02, 8'h00); // key set to direct
        settle_check(); // VGA in window
        set_cfg(8'h07, 8'h80, 8'h03, 8'h00);
        settle_check(); // inverted window
        set_win(16'h0, 16'h0, 16'(ACT_W - 1), 16'(LINES - 1));
        settle_check(); // full screen
        set_win(16'(ACT_W + 1), 16'h0, 16'(ACT_W - 1), 16'(LINES - 1));
        settle_check(); // start off screen
    endtask : t_window

    task automatic t_pin();
        set_cfg(8'h03, 8'h00, 8'h04, 8'h00); // overlay-capable mode
        settle_check(); // pin per pixel
        set_cfg(8'h03, 8'h00, 8'h05, 8'h00);
        settle_check(); // inverted pin
    endtask : t_pin

    task automatic t_key();
        rg = '{8'h20, 8'h9F, 8'h10, 8'h50, 8'h00, 8'hFF, 8'h40, 8'hFF};
        for (int i = 0; i < 8; i++) wr(pss_pkg::IDX_RNG0 + 8'(i), rg[i]);
        set_win(16'h2, 16'h1, 16'h5, 16'h2);
        set_cfg(8'h07, 8'h80, 8'h00, 8'h1F);
        settle_check(); // key on VGA data
        set_cfg(8'h03, 8'h00, 8'h02, 8'h0F);
        settle_check(); // key OR window
        check(32'(hzoom_block), 32'h0, "zoom free"); // VGA port off
    endtask : t_key

    initial begin
        repeat (60) @(posedge mclk);
        #1;
        srst = 1'b0;
        t_reset();
        t_nondirect();
        t_window();
        t_pin();
        t_key();
        tally_and_finish();
    end

    // Hang guard, well above the expected run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            $display("ERROR at %0t: run timed out", $time);
            tally_and_finish();
        end
    end
endmodule : testbench
